// ==== rtl/fls_defines.svh ====
// Constants for the flash command sequencer host: codes, status bits, timing.
// Assumes a 200 MHz controller clock and an asynchronous parallel flash.
`ifndef FLS_DEFINES_SVH
`define FLS_DEFINES_SVH

`define FLS_ADDR_W 20
`define FLS_DATA_W 16

// Command codes written on the low data byte
`define FLS_CODE_READ_ARRAY 8'hFF
`define FLS_CODE_READ_STATUS 8'h70
`define FLS_CODE_ERASE_ALL 8'h30
`define FLS_CODE_CONFIRM 8'hD0
`define FLS_CODE_SUSPEND 8'hB0
`define FLS_CODE_LOCK_SETUP 8'h60
`define FLS_CODE_LOCK_BLOCK 8'h01
`define FLS_CODE_LOCK_PERM 8'hF1
`define FLS_CODE_CLR_STATUS_DEF 8'h50

// Status byte field positions
`define FLS_SR_READY 7
`define FLS_SR_ERASE_ERR 5
`define FLS_SR_WRITE_ERR 4
`define FLS_SR_SUPPLY_LOW 3
`define FLS_SR_WRITE_SUSP 2
`define FLS_SR_PROTECT 1

// Reset values
`define FLS_STATUS_RST 8'h00
`define FLS_RDATA_RST 16'h0000

// Timing in ns and derived cycle counts (least times round up, never below one)
`define FLS_CLK_MHZ 200
`define FLS_T_SETUP_NS 20
`define FLS_T_WP_NS 60
`define FLS_T_HOLD_NS 20
`define FLS_T_ACC_NS 100
`define FLS_CYC_UP(ns) (((ns) * `FLS_CLK_MHZ + 999) / 1000)
`define FLS_CYC_MIN(ns) ((`FLS_CYC_UP(ns) < 1) ? 1 : `FLS_CYC_UP(ns))
`define FLS_SETUP_CYC `FLS_CYC_MIN(`FLS_T_SETUP_NS)
`define FLS_WP_CYC `FLS_CYC_MIN(`FLS_T_WP_NS)
`define FLS_HOLD_CYC `FLS_CYC_MIN(`FLS_T_HOLD_NS)
`define FLS_ACC_CYC `FLS_CYC_MIN(`FLS_T_ACC_NS)
`define FLS_SYNC_CYC 2
`define FLS_POLL_MAX_DEF 32'h0100_0000

`endif

// ==== rtl/fls_pkg.sv ====
// Types shared by the flash command sequencer host.
// Assumes fls_defines.svh is on the include path.
`include "fls_defines.svh"

package fls_pkg;

	typedef enum logic [3:0] {
		FLS_OP_ERASE_ALL = 4'h0,
		FLS_OP_SUSPEND = 4'h1,
		FLS_OP_RESUME = 4'h2,
		FLS_OP_LOCK_BLOCK = 4'h3,
		FLS_OP_LOCK_PERM = 4'h4,
		FLS_OP_CLEAR_LOCKS = 4'h5,
		FLS_OP_READ_STATUS = 4'h6,
		FLS_OP_READ_ARRAY = 4'h7,
		FLS_OP_CLEAR_STATUS = 4'h8
	} fls_op_t;

	typedef enum logic [2:0] {
		FLS_RES_OK = 3'h0,
		FLS_RES_SUPPLY = 3'h1,
		FLS_RES_PROTECT = 3'h2,
		FLS_RES_SEQ = 3'h3,
		FLS_RES_OPERR = 3'h4,
		FLS_RES_TIMEOUT = 3'h5,
		FLS_RES_REFUSED = 3'h6
	} fls_result_t;

	typedef struct packed {
		fls_op_t op;
		logic defer;
		logic [`FLS_ADDR_W-1:0] addr;
	} fls_cmd_t;

	typedef struct packed {
		logic ce_n;
		logic oe_n;
		logic we_n;
	} fls_ctl_t;

endpackage

// ==== rtl/fls_bus_cycle.sv ====
// One asynchronous bus cycle (write or read) on the flash pins.
// Assumes the caller drops req once the cycle is taken; we, addr and wdata are registered at the take.
`include "fls_defines.svh"
module fls_bus_cycle #(
	parameter int DATA_W = `FLS_DATA_W
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic en,
	input wire logic req,
	input wire logic we,
	input wire logic [`FLS_ADDR_W-1:0] addr,
	input wire logic [DATA_W-1:0] wdata,
	output logic idle,
	output logic done,
	output logic [DATA_W-1:0] rdata,
	output fls_pkg::fls_ctl_t ctl,
	output logic [`FLS_ADDR_W-1:0] pin_addr,
	output logic [DATA_W-1:0] pin_dq_o,
	output logic pin_dq_oe_n,
	input wire logic [DATA_W-1:0] pin_dq_i
);

	typedef enum logic [1:0] {
		FLS_B_IDLE = 2'b00,
		FLS_B_SETUP = 2'b01,
		FLS_B_ACT = 2'b10,
		FLS_B_HOLD = 2'b11
	} fls_bstate_t;

	localparam logic [7:0] SETUP_N = 8'(`FLS_SETUP_CYC - 1);
	localparam logic [7:0] WP_N = 8'(`FLS_WP_CYC - 1);
	localparam logic [7:0] ACC_N = 8'(`FLS_ACC_CYC + `FLS_SYNC_CYC - 1);
	localparam logic [7:0] HOLD_N = 8'(`FLS_HOLD_CYC - 1);

	if (`FLS_ACC_CYC + `FLS_SYNC_CYC > 255 || `FLS_WP_CYC > 255) begin : g_chk_cnt
		$error("Bus timing counts exceed the 8-bit counter");
	end

	fls_bstate_t st_ff, nxt_st;
	logic [7:0] cnt_ff, nxt_cnt;
	logic we_ff;
	fls_pkg::fls_ctl_t nxt_ctl;
	logic nxt_oe_n;
	logic [DATA_W-1:0] dq_s1_ff, dq_s2_ff;
	logic cnt_zero;
	logic take;

	assign cnt_zero = (cnt_ff == 8'h00);
	assign take = (st_ff == FLS_B_IDLE) && req;
	assign idle = (st_ff == FLS_B_IDLE);

	// Data pins cross from the flash, so two flops precede the capture
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dq_s1_ff <= '0;
			dq_s2_ff <= '0;
		end else if (en) begin
			dq_s1_ff <= pin_dq_i;
			dq_s2_ff <= dq_s1_ff;
		end
	end

	always_comb begin
		nxt_st = st_ff;
		nxt_cnt = cnt_zero ? cnt_ff : 8'(cnt_ff - 8'h01);
		nxt_ctl = ctl;
		nxt_oe_n = pin_dq_oe_n;
		case (st_ff)
			FLS_B_IDLE: begin
				if (req) begin
					nxt_st = FLS_B_SETUP;
					nxt_cnt = SETUP_N;
					nxt_ctl.ce_n = 1'b0;
					nxt_oe_n = ~we;
				end
			end
			FLS_B_SETUP: begin
				if (cnt_zero) begin
					nxt_st = FLS_B_ACT;
					nxt_cnt = we_ff ? WP_N : ACC_N;
					nxt_ctl.we_n = ~we_ff;
					nxt_ctl.oe_n = we_ff;
				end
			end
			FLS_B_ACT: begin
				if (cnt_zero) begin
					nxt_st = FLS_B_HOLD;
					nxt_cnt = HOLD_N;
					nxt_ctl.we_n = 1'b1;
					nxt_ctl.oe_n = 1'b1;
				end
			end
			default: begin
				if (cnt_zero) begin
					nxt_st = FLS_B_IDLE;
					nxt_ctl.ce_n = 1'b1;
					nxt_oe_n = 1'b1;
				end
			end
		endcase
	end

	// Chip enable goes high between cycles so the device falls back to standby
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_ff <= FLS_B_IDLE;
			cnt_ff <= 8'h00;
			ctl <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
			pin_dq_oe_n <= 1'b1;
			we_ff <= 1'b0;
			done <= 1'b0;
		end else if (en) begin
			st_ff <= nxt_st;
			cnt_ff <= nxt_cnt;
			ctl <= nxt_ctl;
			pin_dq_oe_n <= nxt_oe_n;
			we_ff <= take ? we : we_ff;
			done <= (st_ff == FLS_B_HOLD) && cnt_zero;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_addr <= '0;
			pin_dq_o <= '0;
			rdata <= '0;
		end else if (en) begin
			pin_addr <= take ? addr : pin_addr;
			pin_dq_o <= take ? wdata : pin_dq_o;
			rdata <= (st_ff == FLS_B_ACT && cnt_zero && !we_ff) ? dq_s2_ff : rdata;
		end
	end

endmodule

// ==== rtl/fls_seq_host.sv ====
// Host-side command sequencer for an asynchronous parallel flash.
// Assumes one flash on the pins; the board resolves DQ from FL_DQ_OE_N.
`include "fls_defines.svh"
module fls_seq_host #(
	parameter int DATA_W = `FLS_DATA_W,
	parameter logic [31:0] POLL_MAX = `FLS_POLL_MAX_DEF,
	parameter logic [7:0] CLR_STATUS_CODE = `FLS_CODE_CLR_STATUS_DEF
) (
	input wire logic REF_CLK,
	input wire logic RSTN,
	input wire logic EN,
	input wire logic CMD_VALID,
	input fls_pkg::fls_cmd_t CMD,
	output logic CMD_READY,
	output logic DONE,
	output fls_pkg::fls_result_t RESULT,
	output logic [7:0] STATUS,
	output logic [DATA_W-1:0] RDATA,
	output logic ERR_PENDING,
	output logic [`FLS_ADDR_W-1:0] FL_ADDR,
	output logic [DATA_W-1:0] FL_DQ_O,
	input wire logic [DATA_W-1:0] FL_DQ_I,
	output logic FL_DQ_OE_N,
	output logic FL_CE_N,
	output logic FL_OE_N,
	output logic FL_WE_N,
	output logic FL_RP_N
);

	if (DATA_W < 8 || POLL_MAX == 32'h0) begin : g_chk_par
		$error("DATA_W must hold a status byte and POLL_MAX must be nonzero");
	end

	typedef enum logic [3:0] {
		FLS_S_IDLE = 4'h0,
		FLS_S_PRE_CMD = 4'h1,
		FLS_S_PRE_RD = 4'h2,
		FLS_S_SETUP = 4'h3,
		FLS_S_CONFIRM = 4'h4,
		FLS_S_POLL = 4'h5,
		FLS_S_CHECK = 4'h6,
		FLS_S_EXIT = 4'h7,
		FLS_S_ARR_RD = 4'h8,
		FLS_S_DONE = 4'h9
	} fls_state_t;

	function automatic logic [7:0] setup_code(fls_pkg::fls_op_t op, logic [7:0] clr);
		case (op)
			fls_pkg::FLS_OP_ERASE_ALL: setup_code = `FLS_CODE_ERASE_ALL;
			fls_pkg::FLS_OP_SUSPEND: setup_code = `FLS_CODE_SUSPEND;
			fls_pkg::FLS_OP_RESUME: setup_code = `FLS_CODE_CONFIRM;
			fls_pkg::FLS_OP_READ_STATUS: setup_code = `FLS_CODE_READ_STATUS;
			fls_pkg::FLS_OP_READ_ARRAY: setup_code = `FLS_CODE_READ_ARRAY;
			fls_pkg::FLS_OP_CLEAR_STATUS: setup_code = clr;
			default: setup_code = `FLS_CODE_LOCK_SETUP;
		endcase
	endfunction

	function automatic logic [7:0] confirm_code(fls_pkg::fls_op_t op);
		case (op)
			fls_pkg::FLS_OP_LOCK_BLOCK: confirm_code = `FLS_CODE_LOCK_BLOCK;
			fls_pkg::FLS_OP_LOCK_PERM: confirm_code = `FLS_CODE_LOCK_PERM;
			default: confirm_code = `FLS_CODE_CONFIRM;
		endcase
	endfunction

	// Erase-type operations report in the erase bit, lock sets in the write bit
	function automatic logic is_erase_type(fls_pkg::fls_op_t op);
		is_erase_type = (op == fls_pkg::FLS_OP_ERASE_ALL) || (op == fls_pkg::FLS_OP_CLEAR_LOCKS);
	endfunction

	function automatic logic is_config_op(fls_pkg::fls_op_t op);
		is_config_op = is_erase_type(op) || (op == fls_pkg::FLS_OP_LOCK_BLOCK) ||
			(op == fls_pkg::FLS_OP_LOCK_PERM);
	endfunction

	function automatic fls_pkg::fls_result_t classify(logic [7:0] sr, fls_pkg::fls_op_t op);
		logic op_err;
		op_err = is_erase_type(op) ? sr[`FLS_SR_ERASE_ERR] : sr[`FLS_SR_WRITE_ERR];
		if (sr[`FLS_SR_SUPPLY_LOW]) begin
			classify = fls_pkg::FLS_RES_SUPPLY;
		end else if (sr[`FLS_SR_PROTECT]) begin
			classify = fls_pkg::FLS_RES_PROTECT;
		end else if (sr[`FLS_SR_ERASE_ERR] && sr[`FLS_SR_WRITE_ERR]) begin
			classify = fls_pkg::FLS_RES_SEQ;
		end else if (op_err) begin
			classify = fls_pkg::FLS_RES_OPERR;
		end else begin
			classify = fls_pkg::FLS_RES_OK;
		end
	endfunction

	logic rst_s1_ff, rst_n;
	fls_state_t st_ff, nxt_st;
	fls_pkg::fls_cmd_t cmd_ff;
	logic [31:0] poll_ff;
	logic err_ff, nxt_err;
	fls_pkg::fls_result_t nxt_res;
	logic nxt_done;
	logic bus_req, bus_we, bus_idle, bus_done, wait_ff;
	logic [7:0] bus_code;
	logic [DATA_W-1:0] bus_wdata, bus_rdata;
	logic [7:0] sr_now;
	logic sr_ready, poll_over, refuse, bus_state;
	fls_pkg::fls_ctl_t ctl;

	// Reset release is synchronised; the flash stays in reset until then
	always_ff @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			rst_s1_ff <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_s1_ff <= 1'b1;
			rst_n <= rst_s1_ff;
		end
	end

	assign sr_now = bus_rdata[7:0];
	assign sr_ready = sr_now[`FLS_SR_READY];
	assign poll_over = (poll_ff >= POLL_MAX);
	// Only clear-status and reads pass while an error is outstanding
	assign refuse = err_ff && (CMD.op != fls_pkg::FLS_OP_CLEAR_STATUS) &&
		(CMD.op != fls_pkg::FLS_OP_READ_STATUS) && (CMD.op != fls_pkg::FLS_OP_READ_ARRAY);
	assign bus_state = (st_ff == FLS_S_PRE_CMD) || (st_ff == FLS_S_PRE_RD) ||
		(st_ff == FLS_S_SETUP) || (st_ff == FLS_S_CONFIRM) || (st_ff == FLS_S_POLL) ||
		(st_ff == FLS_S_EXIT) || (st_ff == FLS_S_ARR_RD);
	assign bus_req = bus_state && !wait_ff;
	assign bus_we = (st_ff == FLS_S_PRE_CMD) || (st_ff == FLS_S_SETUP) ||
		(st_ff == FLS_S_CONFIRM) || (st_ff == FLS_S_EXIT);
	assign bus_code = (st_ff == FLS_S_PRE_CMD) ? `FLS_CODE_READ_STATUS :
		(st_ff == FLS_S_CONFIRM) ? confirm_code(cmd_ff.op) :
		(st_ff == FLS_S_EXIT) ? `FLS_CODE_READ_ARRAY : setup_code(cmd_ff.op, CLR_STATUS_CODE);
	assign bus_wdata = DATA_W'(bus_code);
	assign CMD_READY = (st_ff == FLS_S_IDLE);

	always_comb begin
		nxt_st = st_ff;
		nxt_res = RESULT;
		nxt_done = 1'b0;
		nxt_err = err_ff;
		case (st_ff)
			FLS_S_IDLE: begin
				if (CMD_VALID && refuse) begin
					nxt_res = fls_pkg::FLS_RES_REFUSED;
					nxt_st = FLS_S_DONE;
				end else if (CMD_VALID) begin
					nxt_res = fls_pkg::FLS_RES_OK;
					nxt_st = is_config_op(CMD.op) ? FLS_S_PRE_CMD : FLS_S_SETUP;
				end
			end
			FLS_S_PRE_CMD: begin
				if (bus_done) begin
					nxt_st = FLS_S_PRE_RD;
				end
			end
			FLS_S_PRE_RD: begin
				if (bus_done && sr_ready) begin
					nxt_st = FLS_S_SETUP;
				end else if (bus_done && poll_over) begin
					nxt_res = fls_pkg::FLS_RES_TIMEOUT;
					nxt_st = FLS_S_DONE;
				end
			end
			FLS_S_SETUP: begin
				if (bus_done) begin
					case (cmd_ff.op)
						fls_pkg::FLS_OP_SUSPEND: nxt_st = FLS_S_POLL;
						fls_pkg::FLS_OP_READ_STATUS: nxt_st = FLS_S_POLL;
						fls_pkg::FLS_OP_READ_ARRAY: nxt_st = FLS_S_ARR_RD;
						fls_pkg::FLS_OP_RESUME: nxt_st = FLS_S_DONE;
						fls_pkg::FLS_OP_CLEAR_STATUS: begin
							nxt_err = 1'b0;
							nxt_st = FLS_S_DONE;
						end
						default: nxt_st = FLS_S_CONFIRM;
					endcase
				end
			end
			FLS_S_CONFIRM: begin
				if (bus_done) begin
					nxt_st = FLS_S_POLL;
				end
			end
			FLS_S_POLL: begin
				// Error bits mean nothing until ready, so only a ready status is judged
				if (bus_done && (sr_ready || cmd_ff.op == fls_pkg::FLS_OP_READ_STATUS)) begin
					nxt_st = is_config_op(cmd_ff.op) ? FLS_S_CHECK : FLS_S_DONE;
				end else if (bus_done && poll_over) begin
					nxt_res = fls_pkg::FLS_RES_TIMEOUT;
					nxt_st = FLS_S_DONE;
				end
			end
			FLS_S_CHECK: begin
				if (!cmd_ff.defer) begin
					nxt_res = classify(STATUS, cmd_ff.op);
					nxt_err = (classify(STATUS, cmd_ff.op) != fls_pkg::FLS_RES_OK);
					nxt_st = FLS_S_EXIT;
				end else begin
					nxt_st = FLS_S_DONE;
				end
			end
			FLS_S_EXIT: begin
				if (bus_done) begin
					nxt_st = FLS_S_DONE;
				end
			end
			FLS_S_ARR_RD: begin
				if (bus_done) begin
					nxt_st = FLS_S_DONE;
				end
			end
			default: begin
				nxt_done = 1'b1;
				nxt_st = FLS_S_IDLE;
			end
		endcase
	end

	always_ff @(posedge REF_CLK or negedge rst_n) begin
		if (!rst_n) begin
			st_ff <= FLS_S_IDLE;
			cmd_ff <= '0;
			wait_ff <= 1'b0;
			poll_ff <= 32'h0;
			err_ff <= 1'b0;
			RESULT <= fls_pkg::FLS_RES_OK;
			DONE <= 1'b0;
		end else if (EN) begin
			st_ff <= nxt_st;
			cmd_ff <= (st_ff == FLS_S_IDLE && CMD_VALID) ? CMD : cmd_ff;
			wait_ff <= bus_done ? 1'b0 : (wait_ff || (bus_req && bus_idle));
			poll_ff <= (st_ff == FLS_S_IDLE) ? 32'h0 : (bus_done ? poll_ff + 32'h1 : poll_ff);
			err_ff <= nxt_err;
			RESULT <= nxt_res;
			DONE <= nxt_done;
		end
	end

	// Status and data are latched from completed reads only
	always_ff @(posedge REF_CLK or negedge rst_n) begin
		if (!rst_n) begin
			STATUS <= `FLS_STATUS_RST;
			RDATA <= DATA_W'(`FLS_RDATA_RST);
			FL_RP_N <= 1'b0;
		end else if (EN) begin
			STATUS <= (bus_done && !bus_we && st_ff != FLS_S_ARR_RD) ? sr_now : STATUS;
			RDATA <= (bus_done && st_ff == FLS_S_ARR_RD) ? bus_rdata : RDATA;
			FL_RP_N <= 1'b1;
		end
	end

	assign ERR_PENDING = err_ff;
	assign FL_CE_N = ctl.ce_n;
	assign FL_OE_N = ctl.oe_n;
	assign FL_WE_N = ctl.we_n;

	fls_bus_cycle #(
		.DATA_W(DATA_W)
	) u_bus (
		.clk(REF_CLK),
		.rst_n(rst_n),
		.en(EN),
		.req(bus_req),
		.we(bus_we),
		.addr(cmd_ff.addr),
		.wdata(bus_wdata),
		.idle(bus_idle),
		.done(bus_done),
		.rdata(bus_rdata),
		.ctl(ctl),
		.pin_addr(FL_ADDR),
		.pin_dq_o(FL_DQ_O),
		.pin_dq_oe_n(FL_DQ_OE_N),
		.pin_dq_i(FL_DQ_I)
	);

endmodule

// ==== verif/fls_flash_model.sv ====
// Behavioural flash part seen from its pins, with fault inputs.
// Assumes one part on the bus; the controller drives DQ only while dq_oe_n is low.
`include "fls_defines.svh"
module fls_flash_model #(
	parameter logic [7:0] CLR_CODE = `FLS_CODE_CLR_STATUS_DEF
) (
	input wire logic rp_n,
	input wire logic ce_n,
	input wire logic oe_n,
	input wire logic we_n,
	input wire logic [19:0] addr,
	input wire logic [15:0] dq_o,
	input wire logic dq_oe_n,
	output logic [15:0] dq_i,
	input wire logic supply_low,
	input wire logic fail_op,
	input wire logic bad_seq,
	input wire logic writing,
	input wire logic [3:0] busy_reads
);
	timeunit 1ns;
	timeprecision 1ps;
	logic array_ff = 1'b1, perm_ff = 1'b0, susp_ff = 1'b0, erased_ff = 1'b0;
	logic [7:0] sr_ff = 8'h00, pend_ff = 8'h00, code, st;
	logic [15:0] locks_ff = 16'h0000, last_ff = 16'h0000, dout;
	logic [3:0] busy_ff = 4'h0;
	// While busy bits 6:3 read inverted; ready, suspend and bits 1:0 stay true
	assign st = {busy_ff == 4'h0, sr_ff[6:3] ^ {4{busy_ff != 4'h0}}, susp_ff, sr_ff[1:0]};
	assign dout = array_ff ? (erased_ff ? 16'hFFFF : addr[15:0] ^ 16'hC3C3) : {8'h00, st};
	// Floating bus shows the inverse so stale data never passes for a read
	assign dq_i = (!ce_n && !oe_n && rp_n) ? dout : ~last_ff;
	always @(posedge oe_n) begin
		if (!ce_n) begin
			last_ff = dout;
			if (!array_ff && busy_ff != 4'h0) busy_ff = busy_ff - 4'h1;
		end
	end
	always @(posedge we_n or negedge rp_n) begin
		code = dq_oe_n ? 8'h00 : dq_o[7:0];
		if (!rp_n) begin
			array_ff = 1'b1;
			sr_ff = 8'h00;
			pend_ff = 8'h00;
		end else if (!ce_n && pend_ff != 8'h00) begin
			if (bad_seq || (pend_ff == 8'h30 && code != 8'hD0)) sr_ff |= 8'h30;
			else if (supply_low) sr_ff |= (pend_ff == 8'h30 || code == 8'hD0) ? 8'h28 : 8'h18;
			else if (pend_ff == 8'h30 && &locks_ff) sr_ff |= 8'h02;
			else if (pend_ff == 8'h30 && fail_op) sr_ff |= 8'h20;
			else if (pend_ff == 8'h30) erased_ff = 1'b1;
			else if (code != 8'hF1 && perm_ff) sr_ff |= 8'h02;
			else if (code == 8'h01) locks_ff[addr[19:16]] = 1'b1;
			else if (code == 8'hF1) perm_ff = 1'b1;
			else if (code == 8'hD0) locks_ff = 16'h0000;
			else sr_ff |= 8'h30;
			busy_ff = busy_reads;
			pend_ff = 8'h00;
		end else if (!ce_n) begin
			case (code)
				8'h30, 8'h60: pend_ff = code;
				8'h70: array_ff = 1'b0;
				8'hFF: array_ff = 1'b1;
				8'hB0: begin
					susp_ff = writing;
					busy_ff = busy_reads;
				end
				8'hD0: susp_ff = 1'b0;
				CLR_CODE: sr_ff &= 8'hC5;
				default: ;
			endcase
			if (code != 8'hFF && code != 8'hD0) array_ff = 1'b0;
		end
	end
endmodule

// ==== verif/fls_seq_host_props.sv ====
// Port checker for the flash sequencer host.
// Assumes EN stays high, so counts below run at every clock.
`include "fls_defines.svh"
module fls_seq_host_props #(
	parameter int DATA_W = `FLS_DATA_W
) (
	input logic REF_CLK,
	input logic RSTN,
	input logic EN,
	input logic CMD_VALID,
	input fls_pkg::fls_cmd_t CMD,
	input logic CMD_READY,
	input logic DONE,
	input fls_pkg::fls_result_t RESULT,
	input logic ERR_PENDING,
	input logic [DATA_W-1:0] FL_DQ_O,
	input logic FL_DQ_OE_N,
	input logic FL_CE_N,
	input logic FL_OE_N,
	input logic FL_WE_N,
	input logic FL_RP_N
);
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (!RSTN);
	logic take;
	logic [7:0] we_cnt_ff;
	fls_pkg::fls_op_t op_ff;
	assign take = EN && CMD_VALID && CMD_READY;
	always_ff @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			we_cnt_ff <= 8'h00;
			op_ff <= fls_pkg::FLS_OP_READ_ARRAY;
		end else begin
			we_cnt_ff <= FL_WE_N ? 8'h00 : we_cnt_ff + 8'h01;
			if (take) op_ff <= CMD.op;
		end
	end
	sequence s_refused_take;
		take && ERR_PENDING && !(CMD.op inside {fls_pkg::FLS_OP_CLEAR_STATUS,
			fls_pkg::FLS_OP_READ_STATUS, fls_pkg::FLS_OP_READ_ARRAY});
	endsequence
	sequence s_quiet_answer;
		FL_CE_N ##1 (FL_CE_N && DONE && RESULT == fls_pkg::FLS_RES_REFUSED);
	endsequence
	a_refuse_quiet: assert property (s_refused_take |=> s_quiet_answer)
		else $error("refused command not answered quietly");
	a_select_write: assert property (!FL_WE_N |-> !FL_CE_N && !FL_DQ_OE_N && FL_OE_N)
		else $error("write strobe without select or data");
	a_no_contention: assert property (!FL_OE_N |-> FL_DQ_OE_N && !FL_CE_N)
		else $error("controller drives data during a read");
	a_done_pulse: assert property (DONE |-> CMD_READY ##1 !DONE)
		else $error("done not a single pulse with ready");
	a_busy_taken: assert property (take |=> !CMD_READY)
		else $error("ready stayed high after a take");
	a_error_flag: assert property (DONE && RESULT inside {fls_pkg::FLS_RES_SUPPLY,
		fls_pkg::FLS_RES_PROTECT, fls_pkg::FLS_RES_SEQ, fls_pkg::FLS_RES_OPERR} |-> ERR_PENDING)
		else $error("error result without pending flag");
	a_clear_only: assert property ($fell(ERR_PENDING) |-> op_ff == fls_pkg::FLS_OP_CLEAR_STATUS)
		else $error("pending error cleared by another command");
	a_write_width: assert property ($rose(FL_WE_N) |-> we_cnt_ff == 8'(`FLS_WP_CYC))
		else $error("write strobe width wrong");
	a_code_byte: assert property (!FL_WE_N |-> (FL_DQ_O >> 8) == '0)
		else $error("command upper byte not zero");
	a_reset_idle: assert property (!FL_RP_N |-> FL_CE_N && FL_WE_N)
		else $error("flash selected while held in reset");
endmodule
bind fls_seq_host fls_seq_host_props #(.DATA_W(DATA_W)) u_props (.REF_CLK(REF_CLK),
	.RSTN(RSTN), .EN(EN), .CMD_VALID(CMD_VALID), .CMD(CMD), .CMD_READY(CMD_READY),
	.DONE(DONE), .RESULT(RESULT), .ERR_PENDING(ERR_PENDING), .FL_DQ_O(FL_DQ_O),
	.FL_DQ_OE_N(FL_DQ_OE_N), .FL_CE_N(FL_CE_N), .FL_OE_N(FL_OE_N), .FL_WE_N(FL_WE_N),
	.FL_RP_N(FL_RP_N));

// ==== verif/fls_seq_host_test.sv ====
// Self-checking bench: sequencer host against the behavioural flash.
// Assumes the checker is bound in; ops are given as fls_op_t codes.
`include "fls_defines.svh"
module fls_seq_host_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic REF_CLK = 1'b0, RSTN = 1'b0, EN = 1'b1, CMD_VALID = 1'b0;
	fls_pkg::fls_cmd_t CMD = '0;
	logic CMD_READY, DONE, ERR_PENDING, FL_DQ_OE_N, FL_CE_N, FL_OE_N, FL_WE_N, FL_RP_N;
	fls_pkg::fls_result_t RESULT;
	logic [7:0] STATUS;
	logic [15:0] RDATA, FL_DQ_O, FL_DQ_I, locks = 16'h0000;
	logic [19:0] FL_ADDR, a;
	logic supply_low = 1'b0, fail_op = 1'b0, bad_seq = 1'b0, writing = 1'b0;
	logic [3:0] busy_reads = 4'h0, busy_force = 4'h0;
	logic [3:0] f_op [4] = '{4'h0, 4'h0, 4'h3, 4'h3};
	logic [7:0] f_sr [4] = '{8'h28, 8'h20, 8'h30, 8'h18};
	int n_mismatch = 0, total_checks = 0;
	always #2.5 REF_CLK = ~REF_CLK;
	fls_seq_host #(.POLL_MAX(32'h0000_0010)) dut (.REF_CLK(REF_CLK), .RSTN(RSTN), .EN(EN),
		.CMD_VALID(CMD_VALID), .CMD(CMD), .CMD_READY(CMD_READY), .DONE(DONE),
		.RESULT(RESULT), .STATUS(STATUS), .RDATA(RDATA), .ERR_PENDING(ERR_PENDING),
		.FL_ADDR(FL_ADDR), .FL_DQ_O(FL_DQ_O), .FL_DQ_I(FL_DQ_I), .FL_DQ_OE_N(FL_DQ_OE_N),
		.FL_CE_N(FL_CE_N), .FL_OE_N(FL_OE_N), .FL_WE_N(FL_WE_N), .FL_RP_N(FL_RP_N));
	fls_flash_model u_flash (.rp_n(FL_RP_N), .ce_n(FL_CE_N), .oe_n(FL_OE_N), .we_n(FL_WE_N),
		.addr(FL_ADDR), .dq_o(FL_DQ_O), .dq_oe_n(FL_DQ_OE_N), .dq_i(FL_DQ_I),
		.supply_low(supply_low), .fail_op(fail_op), .bad_seq(bad_seq), .writing(writing),
		.busy_reads(busy_reads));
	function automatic logic [2:0] exp_res(input logic [7:0] sr, input logic lock_op);
		if (sr[3]) return 3'h1;
		if (sr[1]) return 3'h2;
		if (sr[5] && sr[4]) return 3'h3;
		if (lock_op ? sr[4] : sr[5]) return 3'h4;
		return 3'h0;
	endfunction
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic run(input logic [3:0] op, input logic [19:0] ad, input logic dfr,
		input logic [2:0] er);
		int n;
		n = 0;
		@(posedge REF_CLK);
		busy_reads <= busy_force | 4'($urandom_range(3));
		CMD_VALID <= 1'b1;
		CMD <= '{fls_pkg::fls_op_t'(op), dfr, ad};
		@(posedge REF_CLK);
		CMD_VALID <= 1'b0;
		do begin
			@(negedge REF_CLK);
			n++;
		end while (DONE !== 1'b1 && n < 4000);
		chk("done", 16'h0001, 16'(DONE));
		chk("result", 16'(er), 16'(RESULT));
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	initial begin
		repeat (40000) @(posedge REF_CLK);
		n_mismatch++;
		$display("[ERR] watchdog expected done seen timeout");
		stop_test();
	end
	initial begin
		void'($urandom(32'hDF5A));
		repeat (6) @(posedge REF_CLK);
		RSTN <= 1'b1;
		repeat (3) @(posedge REF_CLK);
		chk("array_mode", 16'h0001, 16'(u_flash.array_ff));
		a = {4'h3, 16'($urandom)};
		run(4'h7, a, 1'b0, 3'h0);
		chk("rdata", a[15:0] ^ 16'hC3C3, RDATA);
		run(4'h0, a, 1'b0, 3'h0);
		chk("array_mode", 16'h0001, 16'(u_flash.array_ff));
		run(4'h7, a, 1'b0, 3'h0);
		chk("erased", 16'hFFFF, RDATA);
		repeat (4) begin
			a = {4'($urandom_range(15)), 16'h0000};
			locks[a[19:16]] = 1'b1;
			run(4'h3, a, 1'b1, 3'h0);
		end
		chk("locks", locks, u_flash.locks_ff);
		run(4'h5, a, 1'b0, 3'h0);
		chk("locks", 16'h0000, u_flash.locks_ff);
		chk("array_mode", 16'h0001, 16'(u_flash.array_ff));
		for (int b = 0; b < 16; b++) begin
			run(4'h3, {4'(b), 16'h0000}, 1'b1, 3'h0);
		end
		run(4'h0, a, 1'b0, exp_res(8'h02, 1'b0));
		chk("err_pending", 16'h0001, 16'(ERR_PENDING));
		run(4'h3, a, 1'b0, 3'h6);
		run(4'h6, a, 1'b0, 3'h0);
		chk("protect", 16'h0002, 16'(STATUS & 8'h02));
		run(4'h8, a, 1'b0, 3'h0);
		chk("err_pending", 16'h0000, 16'(ERR_PENDING));
		run(4'h5, a, 1'b0, 3'h0);
		for (int k = 0; k < 4; k++) begin
			supply_low <= (k == 0 || k == 3);
			fail_op <= (k == 1);
			bad_seq <= (k == 2);
			run(f_op[k], a, 1'b0, exp_res(f_sr[k], k > 1));
			run(4'h8, a, 1'b0, 3'h0);
		end
		{supply_low, fail_op, bad_seq} <= 3'h0;
		writing <= 1'b1;
		run(4'h1, a, 1'b0, 3'h0);
		chk("suspended", 16'h0004, 16'(STATUS & 8'h04));
		run(4'h7, {4'h9, 16'h1234}, 1'b0, 3'h0);
		chk("rdata", 16'hFFFF, RDATA);
		run(4'h2, a, 1'b0, 3'h0);
		chk("resumed", 16'h0000, 16'(u_flash.susp_ff));
		writing <= 1'b0;
		run(4'h1, a, 1'b0, 3'h0);
		chk("suspended", 16'h0000, 16'(STATUS & 8'h04));
		run(4'h4, a, 1'b0, 3'h0);
		chk("perm", 16'h0001, 16'(u_flash.perm_ff));
		run(4'h3, a, 1'b0, exp_res(8'h02, 1'b1));
		run(4'h8, a, 1'b0, 3'h0);
		run(4'h5, a, 1'b0, exp_res(8'h02, 1'b0));
		run(4'h8, a, 1'b0, 3'h0);
		// A part that stays busy past the poll limit must end in a timeout, not a hang
		busy_force <= 4'hF;
		run(4'h0, a, 1'b0, 3'h5);
		chk("err_pending", 16'h0000, 16'(ERR_PENDING));
		stop_test();
	end
endmodule
